// >>> logic/menu_pkg.sv
// Purpose: shared constants and types of the panel menu sequencer
// Assumes: 10 MHz clock, 12-bit currents in mA
// Notes:   register map is one aligned 32-bit word per register
package menu_pkg;
  localparam int CLK_HZ              = 10_000_000;
  localparam int IDLE_TIMEOUT_SEC    = 12;
  localparam int IDLE_TIMEOUT_CYCLES = IDLE_TIMEOUT_SEC * CLK_HZ;

  localparam logic [6:0]  TOL_MAX   = 7'h63;
  localparam logic [6:0]  TOL_RESET = 7'h0a;
  localparam logic [11:0] CUR_MAX   = 12'hfff;
  localparam logic [2:0]  ALARM_EN_RESET = 3'h7;

  localparam logic [1:0] IFACE_RS232 = 2'h0;
  localparam logic [1:0] IFACE_RS422 = 2'h1;
  localparam logic [1:0] IFACE_RS485 = 2'h2;
  localparam logic [1:0] AMP_LAST    = 2'h2;

  localparam logic [7:0] OFS_STATUS  = 8'h00;
  localparam logic [7:0] OFS_CONTROL = 8'h04;
  localparam logic [7:0] OFS_CONFIG  = 8'h08;
  localparam logic [7:0] OFS_AMP0    = 8'h0c;
  localparam logic [7:0] OFS_FIRST_AMPLIFIER    = 8'h10;
  localparam logic [7:0] OFS_SECOND_AMPLIFIER    = 8'h14;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [3:0] {
    NORMAL, M_MODE, M_CTRL, M_PRIO, WIN_PROMPT, WIN_IND,
    WIN_ACTUAL, WIN_MANUAL, WIN_TOL, M_IFACE, M_ADDR, SAVE
  } menu_state_type;

  typedef struct packed {
    logic execute;
    logic left;
    logic right;
    logic up;
    logic down;
  } switch_type;

  typedef struct packed {
    logic             switchover_mode;
    logic             remote;
    logic             priority2;
    logic [1:0]       iface;
    logic [7:0]       addr;
    logic [2:0][11:0] reference_current;
    logic [2:0][6:0]  tol;
  } settings_type;

  localparam settings_type SETTINGS_RESET = '{
    switchover_mode: 1'b0, remote: 1'b0, priority2: 1'b0,
    iface: IFACE_RS232, addr: 8'h00, reference_current: '0,
    tol: {3{TOL_RESET}}};

  // share of the reference allowed either way
  function automatic logic [11:0] deviation(input logic [11:0] ref_val,
                                            input logic [6:0]  pct);
    logic [18:0] prod;
    prod = ref_val * pct;
    return 12'(prod / 19'h64);
  endfunction

  // measured value outside [ref - dev, ref + dev]
  function automatic logic window_breach(input logic [11:0] ref_val,
                                         input logic [6:0]  pct,
                                         input logic [11:0] meas);
    logic [12:0] hi;
    logic [11:0] lo;
    logic [11:0] dev;
    dev = deviation(ref_val, pct);
    hi  = {1'b0, ref_val} + {1'b0, dev};
    lo  = ref_val - dev;
    return ({1'b0, meas} > hi) || (meas < lo);
  endfunction
endpackage

// >>> logic/front_panel_menu_current_alarm.sv
// Purpose: panel menu sequencer, current windows and alarms, AXI4-Lite regs
// Assumes: panel switches are debounced; measured currents are on clk
// Notes:   settings persist through an external store loaded after reset
`timescale 1ns/100ps

module front_panel_menu_current_alarm #(
  parameter int unsigned IDLE_LIMIT = menu_pkg::IDLE_TIMEOUT_CYCLES
) (
  input  wire logic                     clk,              // 10 MHz clock
  input  wire logic                     rst,              // async reset
  input  wire menu_pkg::switch_type     panel_switch,     // raw panel switches
  input  wire logic [2:0][11:0]         measured_current, // per amplifier
  input  wire menu_pkg::settings_type   nv_restore_data,  // stored settings
  output logic                          store_strobe,     // save pulse
  output menu_pkg::settings_type        store_data,       // data to store
  output menu_pkg::settings_type        active_settings,  // live settings
  output menu_pkg::menu_state_type      menu_screen,      // shown menu
  output logic [1:0]                    selected_amplifier, // menu amp
  output logic                          cursor_on_return, // cursor on R
  output logic                          choice_yes,       // Y/N choice
  output logic [11:0]                   disp_reference,   // shown reference
  output logic [11:0]                   disp_measured,    // shown measured
  output logic [2:0]                    alarm,            // window alarms
  output logic [7:0]                    multidrop_address, // RS485 address
  input  wire logic [7:0]               awaddr,           // write address
  input  wire logic                     awvalid,          // aw valid
  output logic                          awready,          // aw ready
  input  wire logic [31:0]              wdata,            // write data
  input  wire logic [3:0]               wstrb,            // byte enables
  input  wire logic                     wvalid,           // w valid
  output logic                          wready,           // w ready
  output logic [1:0]                    bresp,            // write response
  output logic                          bvalid,           // b valid
  input  wire logic                     bready,           // b ready
  input  wire logic [7:0]               araddr,           // read address
  input  wire logic                     arvalid,          // ar valid
  output logic                          arready,          // ar ready
  output logic [31:0]                   rdata,            // read data
  output logic [1:0]                    rresp,            // read response
  output logic                          rvalid,           // r valid
  input  wire logic                     rready            // r ready
);
  import menu_pkg::*;

  switch_type     sw_sync1_reg;
  switch_type     sw_sync2_reg;
  switch_type     sw_prev_reg;
  switch_type     evt;
  menu_state_type state_reg;
  logic [1:0]     amp_reg;
  logic           ret_reg;
  logic           yes_reg;
  settings_type   shadow_reg;
  settings_type   active_reg;
  logic           loaded_reg;
  logic [31:0]    idle_cnt_reg;
  logic [2:0]     alarm_reg;
  logic [2:0]     alarm_en_reg;
  logic           any_evt;
  logic           session;
  logic           in_menu;
  logic           timeout;
  logic           commit;
  logic           edit;
  logic           do_write;
  logic [11:0]    meas_sel;
  logic [11:0]    ref_sel;
  logic [6:0]     tol_sel;
  logic [31:0]    read_word;
  logic           read_ok;
  logic [7:0]     aw_hold_reg;
  logic [31:0]    w_hold_reg;
  logic [3:0]     strb_hold_reg;

  // two-stage synchroniser, edges taken from the second stage only
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sw_sync1_reg <= '0;
      sw_sync2_reg <= '0;
      sw_prev_reg  <= '0;
    end else begin
      sw_sync1_reg <= panel_switch;
      sw_sync2_reg <= sw_sync1_reg;
      sw_prev_reg  <= sw_sync2_reg;
    end
  end

  // press events and session qualifiers
  assign evt      = sw_sync2_reg & ~sw_prev_reg;
  assign any_evt  = |evt;
  assign session  = (state_reg != NORMAL);
  assign in_menu  = session && (state_reg != SAVE);
  assign edit     = (evt.up || evt.down) && !evt.execute;
  assign commit   = (state_reg == SAVE) && evt.execute && yes_reg;
  assign meas_sel = measured_current[amp_reg];
  assign ref_sel  = shadow_reg.reference_current[amp_reg];
  assign tol_sel  = shadow_reg.tol[amp_reg];
  assign timeout  = session && !any_evt &&
                    (idle_cnt_reg == 32'(IDLE_LIMIT - 1));

  // idle counter restarts on every press; kept wide so long limits fit
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      idle_cnt_reg <= '0;
    end else if (!session || any_evt) begin
      idle_cnt_reg <= '0;
    end else begin
      idle_cnt_reg <= idle_cnt_reg + 32'h1;
    end
  end

  // menu sequencer: screen, amplifier, cursor and Y/N choice
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= NORMAL;
      amp_reg   <= 2'h0;
      ret_reg   <= 1'b0;
      yes_reg   <= 1'b0;
    end else if (timeout) begin
      state_reg <= NORMAL;
      ret_reg   <= 1'b0;
    end else if (evt.execute) begin
      ret_reg <= 1'b0;
      if (ret_reg && in_menu) begin
        state_reg <= SAVE;
        yes_reg   <= 1'b1;
      end else begin
        case (state_reg)
          NORMAL:  state_reg <= M_MODE;
          M_MODE:  state_reg <= M_CTRL;
          M_CTRL:  state_reg <= M_PRIO;
          M_PRIO: begin
            state_reg <= WIN_PROMPT;
            amp_reg   <= 2'h0;
            yes_reg   <= 1'b0;
          end
          WIN_PROMPT: begin
            if (yes_reg) begin
              state_reg <= WIN_IND;
            end else if (amp_reg == AMP_LAST) begin
              state_reg <= M_IFACE;
            end else begin
              amp_reg <= amp_reg + 2'h1;
            end
          end
          WIN_IND: begin
            state_reg <= WIN_ACTUAL;
            yes_reg   <= 1'b1;
          end
          WIN_ACTUAL: state_reg <= yes_reg ? WIN_TOL : WIN_MANUAL;
          WIN_MANUAL: state_reg <= WIN_TOL;
          WIN_TOL: begin
            yes_reg <= 1'b0;
            if (amp_reg == AMP_LAST) begin
              state_reg <= M_IFACE;
            end else begin
              amp_reg   <= amp_reg + 2'h1;
              state_reg <= WIN_PROMPT;
            end
          end
          M_IFACE: state_reg <= M_ADDR;
          M_ADDR: begin
            state_reg <= SAVE;
            yes_reg   <= 1'b1;
          end
          SAVE:    state_reg <= NORMAL;
          default: state_reg <= NORMAL;
        endcase
      end
    end else begin
      // cursor: right parks it on the return marker, left leaves it
      if (evt.right && in_menu) begin
        ret_reg <= 1'b1;
      end else if (evt.left) begin
        ret_reg <= 1'b0;
      end
      if (edit && (state_reg == WIN_PROMPT || state_reg == WIN_ACTUAL ||
                   state_reg == SAVE)) begin
        yes_reg <= ~yes_reg;
      end
    end
  end

  // shadow copy of edits; reloaded from live settings at session start
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      shadow_reg <= SETTINGS_RESET;
    end else if (evt.execute && state_reg == NORMAL) begin
      shadow_reg <= active_reg;
    end else if (evt.execute && state_reg == WIN_ACTUAL && yes_reg &&
                 !ret_reg && !timeout) begin
      shadow_reg.reference_current[amp_reg] <= meas_sel;
    end else if (edit && !timeout) begin
      case (state_reg)
        M_MODE: shadow_reg.switchover_mode <= ~shadow_reg.switchover_mode;
        M_CTRL: shadow_reg.remote    <= ~shadow_reg.remote;
        M_PRIO: shadow_reg.priority2 <= ~shadow_reg.priority2;
        WIN_MANUAL: begin
          if (evt.up && ref_sel != CUR_MAX) begin
            shadow_reg.reference_current[amp_reg] <= ref_sel + 12'h1;
          end else if (!evt.up && ref_sel != 12'h000) begin
            shadow_reg.reference_current[amp_reg] <= ref_sel - 12'h1;
          end
        end
        // tolerance up/down, held within 0..99 percent
        WIN_TOL: begin
          if (evt.up && tol_sel < TOL_MAX) begin
            shadow_reg.tol[amp_reg] <= tol_sel + 7'h1;
          end else if (!evt.up && tol_sel != 7'h00) begin
            shadow_reg.tol[amp_reg] <= tol_sel - 7'h1;
          end
        end
        M_IFACE: begin
          if (evt.up) begin
            shadow_reg.iface <= (shadow_reg.iface == IFACE_RS485) ?
                                IFACE_RS232 : shadow_reg.iface + 2'h1;
          end else begin
            shadow_reg.iface <= (shadow_reg.iface == IFACE_RS232) ?
                                IFACE_RS485 : shadow_reg.iface - 2'h1;
          end
        end
        M_ADDR: begin
          if (evt.up) begin
            shadow_reg.addr <= shadow_reg.addr + 8'h1;
          end else begin
            shadow_reg.addr <= shadow_reg.addr - 8'h1;
          end
        end
        default: shadow_reg <= shadow_reg;
      endcase
    end
  end

  // live settings: restored once after reset, then only a confirmed save
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      active_reg   <= SETTINGS_RESET;
      loaded_reg   <= 1'b0;
      store_strobe <= 1'b0;
      store_data   <= SETTINGS_RESET;
    end else begin
      store_strobe <= 1'b0;
      if (!loaded_reg) begin
        active_reg <= nv_restore_data;
        loaded_reg <= 1'b1;
      end else if (commit) begin
        // commit, a no simply leaves live settings untouched
        active_reg   <= shadow_reg;
        store_strobe <= 1'b1;
        store_data   <= shadow_reg;
      end
    end
  end

  // alarms from live settings; the window is the reference plus or minus tol percent of it
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      alarm_reg <= 3'h0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        alarm_reg[i] <= alarm_en_reg[i] &&
          window_breach(active_reg.reference_current[i],
                        active_reg.tol[i], measured_current[i]);
      end
    end
  end

  // display and status outputs, all registered
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      disp_reference    <= 12'h000;
      disp_measured     <= 12'h000;
      multidrop_address <= 8'h00;
    end else begin
      disp_reference <= ref_sel;
      disp_measured  <= meas_sel;
      multidrop_address <= (active_reg.iface == IFACE_RS485) ?
                           active_reg.addr : 8'h00;
    end
  end

  assign active_settings    = active_reg;
  assign menu_screen        = state_reg;
  assign selected_amplifier = amp_reg;
  assign cursor_on_return   = ret_reg;
  assign choice_yes         = yes_reg;
  assign alarm              = alarm_reg;

  // write channel: address and data taken in either order
  assign do_write = !awready && !wready && !bvalid;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      awready <= 1'b1;
      wready  <= 1'b1;
      bvalid  <= 1'b0;
      bresp   <= RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        awready <= 1'b0;
      end
      if (wvalid && wready) begin
        wready <= 1'b0;
      end
      if (do_write) begin
        bvalid <= 1'b1;
        bresp  <= addr_ok(aw_hold_reg) ? RESP_OKAY : RESP_SLVERR;
      end
      if (bvalid && bready) begin
        bvalid  <= 1'b0;
        awready <= 1'b1;
        wready  <= 1'b1;
      end
    end
  end

  // payload holding and the one writable register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      aw_hold_reg   <= 8'h00;
      w_hold_reg    <= 32'h0;
      strb_hold_reg <= 4'h0;
      alarm_en_reg  <= ALARM_EN_RESET;
    end else begin
      if (awvalid && awready) begin
        aw_hold_reg <= awaddr;
      end
      if (wvalid && wready) begin
        w_hold_reg    <= wdata;
        strb_hold_reg <= wstrb;
      end
      if (do_write && aw_hold_reg == OFS_CONTROL && strb_hold_reg[0]) begin
        alarm_en_reg <= w_hold_reg[2:0];
      end
    end
  end

  function automatic logic addr_ok(input logic [7:0] a);
    return a == OFS_STATUS || a == OFS_CONTROL || a == OFS_CONFIG ||
           a == OFS_AMP0 || a == OFS_FIRST_AMPLIFIER || a == OFS_SECOND_AMPLIFIER;
  endfunction

  // read mux; unmapped words read zero with SLVERR
  always_comb begin
    read_word = 32'h0;
    read_ok   = addr_ok(araddr);
    case (araddr)
      OFS_STATUS:  read_word = {20'h0, session, alarm_reg, yes_reg,
                                ret_reg, amp_reg, state_reg};
      OFS_CONTROL: read_word = {29'h0, alarm_en_reg};
      OFS_CONFIG:  read_word = {15'h0, active_reg.iface == IFACE_RS485,
                                active_reg.addr, 2'h0, active_reg.iface,
                                1'b0, active_reg.priority2, active_reg.remote,
                                active_reg.switchover_mode};
      OFS_AMP0:    read_word = {9'h0, active_reg.tol[0], 4'h0,
                                active_reg.reference_current[0]};
      OFS_FIRST_AMPLIFIER:    read_word = {9'h0, active_reg.tol[1], 4'h0,
                                active_reg.reference_current[1]};
      OFS_SECOND_AMPLIFIER:    read_word = {9'h0, active_reg.tol[2], 4'h0,
                                active_reg.reference_current[2]};
      default:     read_word = 32'h0;
    endcase
  end

  // read channel, one read under way at a time
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= 32'h0;
      rresp   <= RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rdata   <= read_word;
      rresp   <= read_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid && rready) begin
      rvalid  <= 1'b0;
      arready <= 1'b1;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence save_yes_seq;
    commit && loaded_reg;
  endsequence
  sequence save_no_seq;
    state_reg == SAVE && evt.execute && !yes_reg && loaded_reg;
  endsequence

  save_commit_a:
    assert property (save_yes_seq |=> active_reg == $past(shadow_reg) &&
                     store_strobe)
      else $error("save yes did not commit shadow");
  save_discard_a:
    assert property (save_no_seq |=> active_reg == $past(active_reg) &&
                     state_reg == NORMAL && !store_strobe)
      else $error("save no changed live settings");
  return_jump_a:
    assert property (evt.execute && ret_reg && in_menu && !timeout
                     |=> state_reg == SAVE ##1 state_reg == SAVE || evt.execute)
      else $error("return marker did not reach save");
  prio_order_a:
    assert property (state_reg == M_CTRL && evt.execute && !ret_reg &&
                     !timeout |=> state_reg == M_PRIO)
      else $error("priority menu not after control menu");
  manual_skip_a:
    assert property (state_reg == WIN_ACTUAL && evt.execute && yes_reg &&
                     !ret_reg && !timeout |=> state_reg == WIN_TOL)
      else $error("manual entry not skipped on yes");
  actual_copy_a:
    assert property (state_reg == WIN_ACTUAL && evt.execute && yes_reg &&
                     !ret_reg && !timeout
                     |=> shadow_reg.reference_current[amp_reg] == $past(meas_sel))
      else $error("measured current not copied");
  alarm_window_a:
    assert property ((alarm_en_reg[0] && window_breach(
                       active_reg.reference_current[0], active_reg.tol[0],
                       measured_current[0]))[*2] |-> alarm_reg[0])
      else $error("alarm missing for current outside window");
  idle_abandon_a:
    assert property (timeout |=> state_reg == NORMAL &&
                     active_reg == $past(active_reg))
      else $error("idle session not abandoned");
  iface_range_a:
    assert property (shadow_reg.iface != 2'h3)
      else $error("remote interface outside three choices");
  tol_step_a:
    assert property (state_reg == WIN_TOL && edit && evt.up && !timeout &&
                     tol_sel < TOL_MAX |=> tol_sel == $past(tol_sel) + 7'h1)
      else $error("tolerance did not step up");
  restore_a:
    assert property (!loaded_reg |=> active_reg == $past(nv_restore_data))
      else $error("stored settings not restored");
endmodule

// >>> verification/panel_operator.sv
// Purpose: operator at the panel switches
// Assumes: one switch at a time, clean levels
// Notes:   hold outlasts the two-flop sync, gap lets the screen settle
`timescale 1ns/100ps
module panel_operator (
  input  wire logic           clk,         // panel clock
  output menu_pkg::switch_type panel_switch // switch levels
);
  import menu_pkg::*;
  initial panel_switch = '0;
  // one press: a short hold would be missed by the sync
  task automatic press(input logic [4:0] sw);
    @(posedge clk);
    panel_switch <= sw;
    repeat (4) @(posedge clk);
    panel_switch <= '0;
    repeat (4) @(posedge clk);
  endtask
endmodule

// >>> verification/front_panel_menu_current_alarm_tb_top.sv
// Purpose: menu walk, save, revert, timeout and alarm checks
// Assumes: idle limit shortened to 200 cycles
// Notes:   registers read over AXI4-Lite with bounded waits
`timescale 1ns/100ps
module front_panel_menu_current_alarm_tb_top;
  import menu_pkg::*;
  localparam logic [4:0] EXE = 5'h10, LT = 5'h08, RT = 5'h04, UP = 5'h02, DN = 5'h01;
  logic clk, rst, store_strobe, cursor_on_return, choice_yes;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  switch_type panel_switch;
  settings_type nv_restore_data, store_data, active_settings;
  menu_state_type menu_screen;
  logic [2:0][11:0] measured_current;
  logic [1:0] selected_amplifier, bresp, rresp, rs;
  logic [11:0] disp_reference, disp_measured;
  logic [2:0] alarm;
  logic [7:0] multidrop_address, awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0] wstrb;
  logic [11:0] lim [4] = '{12'h457, 12'h456, 12'h379, 12'h37a};
  int mismatches, checks_done, strobes;
  front_panel_menu_current_alarm #(.IDLE_LIMIT(200)) front_panel_menu_current_alarm_i (
    .clk, .rst, .panel_switch, .measured_current, .nv_restore_data, .store_strobe,
    .store_data, .active_settings, .menu_screen, .selected_amplifier, .cursor_on_return,
    .choice_yes, .disp_reference, .disp_measured, .alarm, .multidrop_address, .awaddr,
    .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready,
    .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready);
  panel_operator panel_operator_i (.clk, .panel_switch);
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // a strobe stuck high counts more than once
  always @(posedge clk) if (store_strobe === 1'b1) strobes++;
  task automatic check(input string what, input logic [31:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic results();
    if (mismatches == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic step(inout int n);
    @(posedge clk);
    n++;
    if (n > 200) begin
      mismatches++;
      results();
    end
  endtask
  // both channels offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= d;
    {awvalid, wvalid, bready} <= 3'h7;
    do begin
      step(n);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!((awready || !awvalid) && (wready || !wvalid)));
    do step(n); while (bvalid !== 1'b1);
    rs = bresp;
    bready <= 1'b0;
    // let an edge pass so a following call never re-drives in this step
    @(posedge clk);
  endtask
  task automatic rd_reg(input logic [7:0] a);
    int n;
    n = 0;
    araddr <= a;
    {arvalid, rready} <= 2'h3;
    do step(n); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do step(n); while (rvalid !== 1'b1);
    rd = rdata;
    rs = rresp;
    rready <= 1'b0;
    // let an edge pass so a following call never re-drives in this step
    @(posedge clk);
  endtask
  task automatic go(input logic [4:0] s, input menu_state_type e);
    panel_operator_i.press(s);
    check("screen", 32'(menu_screen), 32'(e));
  endtask
  // main sequence: walk, revert, timeout, alarms
  initial begin
    rst = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hf;
    nv_restore_data = SETTINGS_RESET;
    measured_current = {12'h000, 12'h000, 12'h3e8};
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    rd_reg(OFS_CONTROL);
    check("control", rd, 32'h7);
    rd_reg(8'h40);
    check("unmapped", 32'(rs), 32'(RESP_SLVERR));
    go(EXE, M_MODE);
    go(EXE, M_CTRL);
    go(EXE, M_PRIO);
    go(EXE, WIN_PROMPT);
    go(UP, WIN_PROMPT);
    go(EXE, WIN_IND);
    check("disp ref", 32'(disp_reference), 32'h0);
    check("disp meas", 32'(disp_measured), 32'h3e8);
    go(EXE, WIN_ACTUAL);
    go(EXE, WIN_TOL);
    go(UP, WIN_TOL);
    go(EXE, WIN_PROMPT);
    go(UP, WIN_PROMPT);
    go(EXE, WIN_IND);
    go(EXE, WIN_ACTUAL);
    go(DN, WIN_ACTUAL);
    go(EXE, WIN_MANUAL);
    go(UP, WIN_MANUAL);
    go(EXE, WIN_TOL);
    go(EXE, WIN_PROMPT);
    check("amp", 32'(selected_amplifier), 32'h2);
    go(EXE, M_IFACE);
    go(UP, M_IFACE);
    go(UP, M_IFACE);
    go(EXE, M_ADDR);
    go(UP, M_ADDR);
    go(EXE, SAVE);
    check("live iface", 32'(active_settings.iface), 32'(IFACE_RS232));
    go(EXE, NORMAL);
    check("strobes", 32'(strobes), 32'h1);
    check("store addr", 32'(store_data.addr), 32'h1);
    rd_reg(OFS_AMP0);
    check("amp0", rd, 32'h000b03e8);
    rd_reg(OFS_FIRST_AMPLIFIER);
    check("first_amplifier", rd, 32'h000a0001);
    rd_reg(OFS_CONFIG);
    check("config", rd, 32'h00010120);
    check("address", 32'(multidrop_address), 32'h1);
    go(EXE, M_MODE);
    go(UP, M_MODE);
    go(RT, M_MODE);
    check("cursor", 32'(cursor_on_return), 32'h1);
    go(LT, M_MODE);
    check("cursor left", 32'(cursor_on_return), 32'h0);
    go(RT, M_MODE);
    go(EXE, SAVE);
    go(DN, SAVE);
    check("choice", 32'(choice_yes), 32'h0);
    go(EXE, NORMAL);
    check("revert", 32'(active_settings.switchover_mode), 32'h0);
    check("strobes", 32'(strobes), 32'h1);
    go(EXE, M_MODE);
    go(UP, M_MODE);
    repeat (250) @(posedge clk);
    check("idle", 32'(menu_screen), 32'(NORMAL));
    check("idle mode", 32'(active_settings.switchover_mode), 32'h0);
    // 1000 with 11 percent gives a window of 890 to 1110
    foreach (lim[i]) begin
      measured_current[0] <= lim[i];
      repeat (3) @(posedge clk);
      check("alarm0", 32'(alarm[0]), 32'(i % 2 == 0));
    end
    check("alarms", 32'(alarm), 32'h2);
    wr(OFS_CONTROL, 32'h5);
    check("bresp", 32'(rs), 32'(RESP_OKAY));
    repeat (3) @(posedge clk);
    check("masked", 32'(alarm), 32'h0);
    // second reset: stored settings with RS485 and address 0x2a come back
    nv_restore_data.iface <= IFACE_RS485;
    nv_restore_data.addr <= 8'h2a;
    rst <= 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    check("restored address", 32'(multidrop_address), 32'h2a);
    check("reset alarms", 32'(alarm), 32'h1);
    rd_reg(OFS_CONFIG);
    check("restored config", rd, 32'h00012a20);
    results();
  end
endmodule
